// [pdc_pkg.sv]
// constants, state type and mode helpers for the programmable down counter
package pdc_pkg;

  // datapath widths
  localparam int PDC_CNT_W = 16;
  localparam int PDC_PIN_W = 23;

  // values after reset, and the count step of one
  localparam logic [15:0] PDC_CNT_RST = 16'h0000;
  localparam logic [15:0] PDC_CNT_ONE = 16'h0001;
  localparam logic [22:0] PDC_PIN_RST = 23'h00_0000;
  localparam logic PDC_OUT_RST = 1'b0;

  // mode select codes
  localparam logic [2:0] PDC_MODE_LVL = 3'h0;
  localparam logic [2:0] PDC_MODE_LVL_INV = 3'h1;
  localparam logic [2:0] PDC_MODE_PLS = 3'h2;
  localparam logic [2:0] PDC_MODE_PLS_INV = 3'h3;
  localparam logic [2:0] PDC_MODE_HLD = 3'h4;
  localparam logic [2:0] PDC_MODE_HLD_INV = 3'h5;
  localparam logic [2:0] PDC_MODE_ONE = 3'h6;
  localparam logic [2:0] PDC_MODE_FRQ = 3'h7;

  // bit positions inside the synchronised pin bundle
  localparam int PDC_PIN_DATA = 0;
  localparam int PDC_PIN_MODE = 16;
  localparam int PDC_PIN_WR_N = 19;
  localparam int PDC_PIN_CP = 20;
  localparam int PDC_PIN_TRIG = 21;
  localparam int PDC_PIN_CLR_N = 22;

  typedef enum logic [1:0] {
    PDC_IDLE,
    PDC_LOADED,
    PDC_COUNT
  } pdc_state_t;

  // modes whose active output lasts one count-clock period
  function automatic logic pdc_is_pulse(input logic [2:0] mode);
    pdc_is_pulse = (mode != PDC_MODE_LVL) && (mode != PDC_MODE_LVL_INV) &&
                   (mode != PDC_MODE_ONE);
  endfunction : pdc_is_pulse

  // odd timer modes drive the zero output inverted
  function automatic logic pdc_inverts(input logic [2:0] mode);
    pdc_inverts = mode[0] && (mode != PDC_MODE_FRQ);
  endfunction : pdc_inverts

  // count-hold family
  function automatic logic pdc_is_hold(input logic [2:0] mode);
    pdc_is_hold = (mode == PDC_MODE_HLD) || (mode == PDC_MODE_HLD_INV);
  endfunction : pdc_is_hold

endpackage : pdc_pkg

// [pdc_sync.sv]
// two-stage synchroniser for the asynchronous input pins
`timescale 1ns/1ps
module pdc_sync import pdc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [PDC_PIN_W-1:0] pins_in,
  output logic [PDC_PIN_W-1:0] pins_out
);

  typedef struct packed {
    logic [PDC_PIN_W-1:0] s1;
    logic [PDC_PIN_W-1:0] s2;
  } pdc_sync_t;

  pdc_sync_t r;
  pdc_sync_t next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r = r;
    next_r.s1 = pins_in;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= {PDC_PIN_RST, PDC_PIN_RST};
    end else begin
      r <= next_r;
    end
  end

  assign pins_out = r.s2;

endmodule : pdc_sync

// [pdc_latch.sv]
// preset latch: follows data while the strobe is low, holds once high
`timescale 1ns/1ps
module pdc_latch import pdc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [PDC_CNT_W-1:0] data_in,
  input wire logic preset_write_n,
  output logic [PDC_CNT_W-1:0] preset_value
);

  typedef struct packed {
    logic [PDC_CNT_W-1:0] val;
  } pdc_latch_t;

  pdc_latch_t r;
  pdc_latch_t next_r;

  // transparent while low, so the value held is the last seen before the rise
  always_comb begin
    next_r = r;
    if (!preset_write_n) begin
      next_r.val = data_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= PDC_CNT_RST;
    end else begin
      r <= next_r;
    end
  end

  assign preset_value = r.val;

endmodule : pdc_latch

// [pdc_counter.sv]
// programmable down counter: mode decode, count engine and outputs
`timescale 1ns/1ps
// Functional notes
// - mode_select picks level, pulse, hold, one-shot or frequency modes
// - trigger high loads the preset into the counter on each count edge, except while a hold mode counts down
// - first count edge after trigger falls starts the decrement
// - level modes hold zero output active at zero; half output toggles
// - level modes: next trigger clears the zero output
// - odd timer modes invert the zero output of the even mode; half output is the same
// - pulse modes: zero output active one count period; half toggles
// - hold modes: trigger during count-down freezes the count
// - hold modes: reload accepted in every state except while counting down
// - hold modes: one-period pulse plus half toggle at zero
// - one-shot: edge that starts count-down raises the zero output
// - one-shot: zero drops the zero output and toggles half
// - one-shot: trigger before zero reloads without touching output
// - preset zero halts counting; host avoids preset one in one-shot
// - frequency mode starts counting on first edge after trigger falls
// - frequency mode: one-period pulse at zero, half toggles on its rise
// - frequency mode reloads on the edge ending the pulse, runs on
// - preset latch transparent while strobe low, captures on its rise
// - frequency mode runs until master clear
// - inverted modes toggle half on the falling zero output
module pdc_counter import pdc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic count_clock,
  input wire logic ext_trigger,
  input wire logic master_clear_n,
  input wire logic [2:0] mode_select,
  input wire logic [PDC_CNT_W-1:0] preset_value_in,
  input wire logic preset_write_n,
  output logic zero_out,
  output logic half_out
);

  typedef struct packed {
    pdc_state_t state;
    logic [PDC_CNT_W-1:0] cnt;
    logic q_act;
    logic half;
    logic zero_out;
    logic cp_prev;
  } pdc_core_t;

  pdc_core_t r;
  pdc_core_t next_r;

  logic [PDC_PIN_W-1:0] pins_s;
  logic [PDC_CNT_W-1:0] preset;
  logic cp_s;
  logic trig_s;
  logic clr_n_s;
  logic [2:0] mode_s;
  logic cp_rise;
  logic [PDC_CNT_W-1:0] dec;

  // every pin crosses two flops before any logic sees it
  pdc_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins_in({master_clear_n, ext_trigger, count_clock, preset_write_n,
              mode_select, preset_value_in}),
    .pins_out(pins_s)
  );

  // sixteen-bit preset held independent of mode
  pdc_latch u_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .data_in(pins_s[PDC_PIN_DATA +: PDC_CNT_W]),
    .preset_write_n(pins_s[PDC_PIN_WR_N]),
    .preset_value(preset)
  );

  // unpack the synchronised bundle
  assign cp_s = pins_s[PDC_PIN_CP];
  assign trig_s = pins_s[PDC_PIN_TRIG];
  assign clr_n_s = pins_s[PDC_PIN_CLR_N];
  assign mode_s = pins_s[PDC_PIN_MODE +: 3];
  assign cp_rise = cp_s && !r.cp_prev;
  assign dec = r.cnt - PDC_CNT_ONE;

  // count engine, advanced only on a count-clock rising edge
  always_comb begin
    next_r = r;
    next_r.cp_prev = cp_s;
    if (!clr_n_s) begin
      // clear wins over everything, even a running generator
      next_r.state = PDC_IDLE;
      next_r.cnt = PDC_CNT_RST;
      next_r.q_act = PDC_OUT_RST;
      next_r.half = PDC_OUT_RST;
    end else if (cp_rise) begin
      // a one-period pulse ends on the following count edge
      if (r.q_act && pdc_is_pulse(mode_s)) begin
        next_r.q_act = 1'b0;
      end
      if (trig_s) begin
        if (pdc_is_hold(mode_s) && r.state == PDC_COUNT) begin
          next_r.q_act = r.q_act; // frozen count
        end else begin
          next_r.cnt = preset;
          next_r.state = PDC_LOADED;
          if (mode_s != PDC_MODE_ONE) begin
            next_r.q_act = 1'b0;
          end
        end
      end else begin
        case (r.state)
          PDC_LOADED: begin
            if (r.cnt == PDC_CNT_RST) begin
              next_r.state = PDC_IDLE; // zero preset idles
            end else begin
              next_r.state = PDC_COUNT;
              next_r.cnt = dec;
              if (mode_s == PDC_MODE_ONE) begin
                next_r.q_act = 1'b1;
              end
              if (dec == PDC_CNT_RST) begin
                next_r.half = !r.half;
                next_r.q_act = (mode_s != PDC_MODE_ONE);
                next_r.state = (mode_s == PDC_MODE_FRQ) ? PDC_COUNT : PDC_IDLE;
              end
            end
          end
          PDC_COUNT: begin
            if (r.cnt == PDC_CNT_RST) begin
              // generator reloads on the edge that ends its pulse
              next_r.cnt = preset;
              next_r.state = (preset == PDC_CNT_RST) ? PDC_IDLE : PDC_COUNT;
            end else begin
              next_r.cnt = dec;
              if (dec == PDC_CNT_RST) begin
                // half follows the active edge, the falling pin in odd timer modes
                next_r.half = !r.half;
                next_r.q_act = (mode_s != PDC_MODE_ONE);
                next_r.state = (mode_s == PDC_MODE_FRQ) ? PDC_COUNT : PDC_IDLE;
              end
            end
          end
          default: begin
            next_r.state = PDC_IDLE;
          end
        endcase
      end
    end
    // registered pin level; odd timer modes invert
    next_r.zero_out = next_r.q_act ^ pdc_inverts(mode_s);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: PDC_IDLE, cnt: PDC_CNT_RST, q_act: PDC_OUT_RST,
             half: PDC_OUT_RST, zero_out: PDC_OUT_RST, cp_prev: PDC_OUT_RST};
    end else begin
      r <= next_r;
    end
  end

  assign zero_out = r.zero_out;
  assign half_out = r.half;

  // checks on the count engine
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_clear_idles: assert property (
    !clr_n_s |=> (r.state == PDC_IDLE) && !r.q_act && !r.half &&
      (r.cnt == PDC_CNT_RST))
    else $error("master clear did not idle the counter");

  a_trig_loads: assert property (
    clr_n_s && cp_rise && trig_s &&
      !(pdc_is_hold(mode_s) && r.state == PDC_COUNT)
      |=> r.cnt == $past(preset))
    else $error("trigger edge did not load the preset");

  a_hold_freeze: assert property (
    clr_n_s && cp_rise && trig_s && pdc_is_hold(mode_s) &&
      r.state == PDC_COUNT |=> r.cnt == $past(r.cnt))
    else $error("count moved while held");

  a_count_step: assert property (
    clr_n_s && cp_rise && !trig_s && r.state == PDC_COUNT &&
      r.cnt > PDC_CNT_ONE |=> r.cnt == $past(dec))
    else $error("counter did not decrement");

  a_pulse_one: assert property (
    clr_n_s && cp_rise && r.q_act && pdc_is_pulse(mode_s) |=> !r.q_act)
    else $error("pulse lasted past one count period");

  a_level_holds: assert property (
    clr_n_s && cp_rise && !trig_s && r.q_act &&
      (mode_s == PDC_MODE_LVL || mode_s == PDC_MODE_LVL_INV) |=> r.q_act)
    else $error("level output dropped without trigger");

  a_half_toggle: assert property (
    $rose(r.q_act) && $past(clr_n_s) && mode_s != PDC_MODE_ONE
      |-> r.half != $past(r.half))
    else $error("half output missed the active edge");

  a_shot_start: assert property (
    clr_n_s && cp_rise && !trig_s && mode_s == PDC_MODE_ONE &&
      r.state == PDC_LOADED && r.cnt > PDC_CNT_ONE |=> r.q_act)
    else $error("one-shot output not raised at start");

  a_shot_end: assert property (
    $fell(r.q_act) && $past(clr_n_s) && $past(!trig_s) &&
      mode_s == PDC_MODE_ONE |-> r.half != $past(r.half))
    else $error("one-shot end did not toggle half");

  a_zero_halts: assert property (
    clr_n_s && cp_rise && !trig_s && r.state == PDC_LOADED &&
      r.cnt == PDC_CNT_RST |=> r.state == PDC_IDLE)
    else $error("zero preset did not halt");

  a_gen_reload: assert property (
    clr_n_s && cp_rise && !trig_s && mode_s == PDC_MODE_FRQ &&
      r.state == PDC_COUNT && r.cnt == PDC_CNT_RST
      |=> r.cnt == $past(preset))
    else $error("generator did not reload");

  a_pin_polar: assert property (
    ##1 r.zero_out == (r.q_act ^ $past(pdc_inverts(mode_s))))
    else $error("zero output polarity wrong");

  // per-mode checks at the terminal count, on a trigger and at the generator start
  a_level_clear: assert property (
    clr_n_s && cp_rise && trig_s &&
      (mode_s == PDC_MODE_LVL || mode_s == PDC_MODE_LVL_INV) |=> !r.q_act)
    else $error("trigger did not clear the level output");

  a_level_reach: assert property (
    clr_n_s && cp_rise && !trig_s && r.state == PDC_COUNT &&
      r.cnt == PDC_CNT_ONE &&
      (mode_s == PDC_MODE_LVL || mode_s == PDC_MODE_LVL_INV)
      |=> r.q_act && r.half != $past(r.half))
    else $error("level output not raised at zero");

  a_pulse_reach: assert property (
    clr_n_s && cp_rise && !trig_s && r.state == PDC_COUNT &&
      r.cnt == PDC_CNT_ONE &&
      (mode_s == PDC_MODE_PLS || mode_s == PDC_MODE_PLS_INV)
      |=> r.q_act && r.half != $past(r.half) && r.state == PDC_IDLE)
    else $error("pulse output not raised at zero");

  a_hold_reload: assert property (
    clr_n_s && cp_rise && trig_s && pdc_is_hold(mode_s) &&
      r.state != PDC_COUNT
      |=> r.state == PDC_LOADED && r.cnt == $past(preset))
    else $error("hold mode refused a reload after zero");

  a_hold_reach: assert property (
    clr_n_s && cp_rise && !trig_s && r.state == PDC_COUNT &&
      r.cnt == PDC_CNT_ONE && pdc_is_hold(mode_s)
      |=> r.q_act && r.half != $past(r.half) && r.state == PDC_IDLE)
    else $error("hold mode missed its zero pulse");

  a_shot_retrig: assert property (
    clr_n_s && cp_rise && trig_s && mode_s == PDC_MODE_ONE
      |=> r.q_act == $past(r.q_act) && r.cnt == $past(preset))
    else $error("one-shot retrigger touched the output");

  a_shot_zero: assert property (
    clr_n_s && cp_rise && !trig_s && mode_s == PDC_MODE_ONE &&
      r.state == PDC_COUNT && r.cnt == PDC_CNT_ONE
      |=> !r.q_act && r.half != $past(r.half))
    else $error("one-shot did not end at zero");

  a_gen_start: assert property (
    clr_n_s && cp_rise && !trig_s && mode_s == PDC_MODE_FRQ &&
      r.state == PDC_LOADED && r.cnt > PDC_CNT_ONE
      |=> r.state == PDC_COUNT && r.cnt == $past(dec))
    else $error("generator did not start counting");

  a_gen_pulse: assert property (
    clr_n_s && cp_rise && !trig_s && mode_s == PDC_MODE_FRQ &&
      r.state == PDC_COUNT && r.cnt == PDC_CNT_ONE
      |=> r.q_act && r.half != $past(r.half) && r.state == PDC_COUNT)
    else $error("generator missed its zero pulse");

  // the generator never stops by itself once running
  a_gen_runs: assert property (
    clr_n_s && !trig_s && mode_s == PDC_MODE_FRQ &&
      r.state == PDC_COUNT &&
      (r.cnt != PDC_CNT_RST || preset != PDC_CNT_RST)
      |=> r.state == PDC_COUNT)
    else $error("generator stopped without a clear");

  // inverted modes: the half output moves as the pin falls
  a_inv_half: assert property (
    $changed(r.half) && $past(clr_n_s) && $past(pdc_inverts(mode_s)) &&
      $past(pdc_inverts(mode_s), 2) |-> $fell(r.zero_out))
    else $error("half output missed the falling pin");

  // no count edge, no change of count, active level or half output
  a_out_quiet: assert property (
    clr_n_s && !cp_rise
      |=> $stable(r.q_act) && $stable(r.half) && $stable(r.cnt))
    else $error("state moved without a count edge");

  a_idle_stays: assert property (
    clr_n_s && !trig_s && r.state == PDC_IDLE
      |=> r.state == PDC_IDLE && $stable(r.cnt))
    else $error("idle counter moved without a trigger");

  a_clear_pin: assert property (
    !clr_n_s |=> r.zero_out == $past(pdc_inverts(mode_s)))
    else $error("cleared pin not at its rest level");

endmodule : pdc_counter

// [pdc_host_model.sv]
// controlling logic model: mode pins, preset writes, trigger, count edges
`timescale 1ns/1ps
module pdc_host_model import pdc_pkg::*; (
  input wire logic clk,
  output logic count_clock,
  output logic ext_trigger,
  output logic master_clear_n,
  output logic [2:0] mode_select,
  output logic [15:0] preset_value_in,
  output logic preset_write_n
);
  // idle pin levels at time zero
  initial begin
    count_clock = 1'b0;
    ext_trigger = 1'b0;
    master_clear_n = 1'b1;
    mode_select = PDC_MODE_LVL;
    preset_value_in = 16'h0000;
    preset_write_n = 1'b1;
  end

  // latch write; the data line changes once the strobe has risen
  task automatic write_preset(input logic [15:0] v);
    if (mode_select == PDC_MODE_ONE && v == PDC_CNT_ONE) v = 16'h0002;
    @(posedge clk) preset_write_n <= 1'b0;
    preset_value_in <= v;
    repeat (2) @(posedge clk);
    preset_write_n <= 1'b1;
    @(posedge clk) preset_value_in <= ~v;
  endtask : write_preset

  // mode pins; every code is legal
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk) mode_select <= m;
  endtask : set_mode

  task automatic set_trig(input logic v);
    @(posedge clk) ext_trigger <= v;
  endtask : set_trig

  // 4 low then 5 high: covers the 3-cycle setup and 2-cycle minimum width
  task automatic count_edge();
    repeat (4) @(posedge clk);
    count_clock <= 1'b1;
    repeat (5) @(posedge clk);
    count_clock <= 1'b0;
  endtask : count_edge

  // clear pulse, then time for the synchroniser to release it
  task automatic clear();
    @(posedge clk) master_clear_n <= 1'b0;
    repeat (3) @(posedge clk);
    master_clear_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : clear
endmodule : pdc_host_model

// [programmable_down_counter_tb_top.sv]
// self-checking bench for the programmable down counter
`timescale 1ns/1ps
module programmable_down_counter_tb_top import pdc_pkg::*;;
  logic clk;
  logic sys_rst;
  logic count_clock;
  logic ext_trigger;
  logic master_clear_n;
  logic [2:0] mode_select;
  logic [15:0] preset_value_in;
  logic preset_write_n;
  logic zero_out;
  logic half_out;
  int num_errors = 0;
  int checked = 0;
  logic inv = 1'b0;
  logic exp_h = 1'b0;

  pdc_counter u_pdc_counter (.clk(clk), .sys_rst(sys_rst),
    .count_clock(count_clock), .ext_trigger(ext_trigger),
    .master_clear_n(master_clear_n), .mode_select(mode_select),
    .preset_value_in(preset_value_in), .preset_write_n(preset_write_n),
    .zero_out(zero_out), .half_out(half_out));

  pdc_host_model u_pdc_host_model (.clk(clk), .count_clock(count_clock),
    .ext_trigger(ext_trigger), .master_clear_n(master_clear_n),
    .mode_select(mode_select), .preset_value_in(preset_value_in),
    .preset_write_n(preset_write_n));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // act is the active level before polarity; half against running model
  task automatic chk(input logic act);
    checked++;
    if (zero_out !== (act ^ inv) || half_out !== exp_h) begin
      num_errors++;
      $display("CHECK FAILED t=%0t zero %b half %b want act %b half %b",
               $time, zero_out, half_out, act, exp_h);
    end
  endtask : chk

  // one count edge; outputs have settled when the high phase ends
  task automatic step(input logic act, input logic tog);
    u_pdc_host_model.count_edge();
    if (tog) exp_h = ~exp_h;
    chk(act);
  endtask : step

  // clear, write the preset and load it with one triggered edge
  task automatic start(input logic [2:0] m, input logic [15:0] v);
    u_pdc_host_model.set_mode(m);
    inv = m[0] && (m != PDC_MODE_FRQ);
    exp_h = 1'b0;
    u_pdc_host_model.clear();
    chk(1'b0);
    u_pdc_host_model.write_preset(v);
    u_pdc_host_model.set_trig(1'b1);
    step(1'b0, 1'b0);
    u_pdc_host_model.set_trig(1'b0);
  endtask : start

  task automatic s_level();
    for (int m = 0; m < 2; m++) begin
      start(3'(m), 16'h0003);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      u_pdc_host_model.set_trig(1'b1);
      step(1'b0, 1'b0);
      u_pdc_host_model.set_trig(1'b0);
    end
  endtask : s_level

  task automatic s_pulse();
    for (int m = 2; m < 4; m++) begin
      start(3'(m), 16'h0002);
      step(1'b0, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask : s_pulse

  // a frozen count of 2 reaches zero two edges after release
  task automatic s_hold();
    for (int m = 4; m < 6; m++) begin
      start(3'(m), 16'h0003);
      step(1'b0, 1'b0);
      u_pdc_host_model.set_trig(1'b1);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      u_pdc_host_model.set_trig(1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b0);
      u_pdc_host_model.set_trig(1'b1);
      step(1'b0, 1'b0);
      u_pdc_host_model.set_trig(1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b1);
    end
  endtask : s_hold

  task automatic s_one();
    start(PDC_MODE_ONE, 16'h0003);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    u_pdc_host_model.set_trig(1'b1);
    step(1'b1, 1'b0);
    u_pdc_host_model.set_trig(1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask : s_one

  task automatic s_freq();
    start(PDC_MODE_FRQ, 16'h0002);
    step(1'b0, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    step(1'b1, 1'b1);
    exp_h = 1'b0;
    u_pdc_host_model.clear();
    chk(1'b0);
    for (int i = 0; i < 3; i++) step(1'b0, 1'b0);
  endtask : s_freq

  // a zero preset never reaches a terminal count
  task automatic s_zero();
    start(PDC_MODE_PLS, 16'h0000);
    for (int i = 0; i < 4; i++) step(1'b0, 1'b0);
  endtask : s_zero

  // a mid-run reset stops a count and leaves the outputs idle
  task automatic s_reset();
    start(PDC_MODE_LVL_INV, 16'h0002);
    step(1'b0, 1'b0);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    exp_h = 1'b0;
    chk(1'b1);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
  endtask : s_reset

  // a preset beyond eight bits runs the full-width count
  task automatic s_wide();
    start(PDC_MODE_PLS, 16'h0180);
    for (int i = 0; i < 383; i++) step(1'b0, 1'b0);
    step(1'b1, 1'b1);
  endtask : s_wide

  // main sequence: reset, then every mode
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    chk(1'b0);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    s_level();
    s_pulse();
    s_hold();
    s_one();
    s_freq();
    s_zero();
    s_reset();
    s_wide();
    end_sim();
  end

  // hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule : programmable_down_counter_tb_top
